// [ocg_pkg.sv]
// Purpose : Constants and carrier types for the over-current guard register bank
// Assumes : Avalon-MM word addressing by byte address, 8-bit registers in low lanes
// Notes   : Operation list below
//
// Operation
// - Mode zero disables protection and sets the switch network to disabled state
// - Disabled: amplifier, comparator, converter, filter powered down; result forced low
// - Mode one enables non-inverting gain, switch pair S0 S3 closed
// - Mode two enables inverting gain, switch pair S1 S2 closed
// - Mode three enables zero-volt input for offset calibration
// - Low six bits of mode register read as zero
// - Top bit of gain register shows filtered trip result, read only
// - Three-bit gain field selects amplifier gain for either polarity
// - Three-bit filter field: zero bypasses, code n needs about 2^n periods
// - Eight-bit threshold code drives the reference converter, resets to zero
// - Amplifier calibration top bit selects offset cancellation state
// - Amplifier calibration bit six selects cancellation reference input
// - Amplifier calibration low six bits hold trim code, reset zero
// - Probe bit shows amplifier output during amplifier cancellation
// - Probe bit shows comparator output during comparator cancellation with amplifier cancellation off
// - Asserted trip result shuts off PWM and raises interrupt request
package ocg_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [4:0] OCG_ADDR_MODE  = 5'h00;
    localparam logic [4:0] OCG_ADDR_GAIN  = 5'h04;
    localparam logic [4:0] OCG_ADDR_THR   = 5'h08;
    localparam logic [4:0] OCG_ADDR_ACAL  = 5'h0C;
    localparam logic [4:0] OCG_ADDR_CCAL  = 5'h10;
    localparam logic [4:0] OCG_ADDR_MISC  = 5'h14;
    localparam logic [7:0] OCG_RST_VAL    = 8'h00;
    localparam logic [31:0] OCG_UNMAPPED  = 32'h00000000;

    // Field positions
    localparam int OCG_MODE_LSB    = 6;
    localparam int OCG_TRIP_BIT    = 7;
    localparam int OCG_GAIN_LSB    = 3;
    localparam int OCG_CANCEL_BIT  = 7;
    localparam int OCG_REFSEL_BIT  = 6;
    localparam int OCG_PROBE_BIT   = 7;
    localparam int OCG_MISC_SRC    = 6;

    // Filter tick: crystal clock divided by four
    localparam int OCG_TICK_DIV    = 4;
    localparam logic [1:0] OCG_TICK_LAST = 2'(OCG_TICK_DIV - 1);

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        OCG_MODE_OFF  = 2'h0,
        OCG_MODE_NINV = 2'h1,
        OCG_MODE_INV  = 2'h2,
        OCG_MODE_ZERO = 2'h3
    } ocg_mode_t;

    typedef enum logic [2:0] {
        OCG_FS_STABLE = 3'h1,
        OCG_FS_COUNT  = 3'h2,
        OCG_FS_OFF    = 3'h4
    } ocg_fstate_t;

    // Controls toward the analogue front end
    typedef struct packed {
        logic       amp_en;
        logic       cmp_en;
        logic       dac_en;
        logic [3:0] sw_close;
        logic       amp_inverting;
        logic [2:0] amp_gain_sel;
        logic [7:0] threshold_code;
        logic       amp_cancel_mode;
        logic       amp_cancel_ref_sel;
        logic [5:0] amp_trim_code;
        logic       cmp_cancel_mode;
        logic       cmp_cancel_ref_sel;
        logic [4:0] cmp_trim_code;
        logic       threshold_ref_src;
    } ocg_afe_ctrl_t;

    // Switch patterns, bit i drives switch Si
    localparam logic [3:0] OCG_SW_OFF  = 4'hA;
    localparam logic [3:0] OCG_SW_NINV = 4'h9;
    localparam logic [3:0] OCG_SW_INV  = 4'h6;
    localparam logic [3:0] OCG_SW_ZERO = 4'hA;

endpackage

// [ocg_ctrl.sv]
// Purpose : Over-current guard register bank and comparator debounce filter
// Assumes : Avalon-MM slave, one-cycle waitrequest on every access
// Notes   : Comparator and amplifier outputs taken as synchronous to REF_CLK
//
// Design decisions made here: the address map and register access over Avalon-MM.
module ocg_ctrl
    import ocg_pkg::*;
(
    input  wire logic          REF_CLK,
    input  wire logic          ARST_N,
    input  wire logic [4:0]    AVS_ADDRESS,
    input  wire logic          AVS_READ,
    input  wire logic          AVS_WRITE,
    input  wire logic [31:0]   AVS_WRITEDATA,
    input  wire logic [3:0]    AVS_BYTEENABLE,
    output logic [31:0]        AVS_READDATA,
    output logic               AVS_WAITREQUEST,
    input  wire logic          CMP_RAW,
    input  wire logic          AMP_OUT_LVL,
    output ocg_afe_ctrl_t      AFE_CTRL,
    output logic               FILTER_EN,
    output logic               TRIP_FLAG,
    output logic               PWM_SHUTOFF,
    output logic               TRIP_IRQ
);

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_s1_r;
    logic rst_n_r;

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [1:0]  mode_r,  mode_nxt;
    logic [2:0]  gain_r,  gain_nxt;
    logic [2:0]  flen_r,  flen_nxt;
    logic [7:0]  thr_r,   thr_nxt;
    logic [7:0]  acal_r,  acal_nxt;
    logic [6:0]  ccal_r,  ccal_nxt;
    logic        src_r,   src_nxt;
    logic        ack_r,   ack_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [7:0]  rd_byte;
    logic        req;
    logic        wr_hit;
    logic        trip_r;
    logic        probe;

    assign req    = AVS_READ | AVS_WRITE;
    // Writes land on the completing edge, never while the master still waits
    assign wr_hit = AVS_WRITE & ack_r & AVS_BYTEENABLE[0];
    // Waitrequest drops in the second cycle of each request
    assign AVS_WAITREQUEST = req & ~ack_r;
    assign AVS_READDATA    = rdata_r;

    // Probe follows the block in cancellation, the amplifier when both are
    always_comb begin
        probe = 1'b0;
        if (acal_r[OCG_CANCEL_BIT]) begin
            probe = AMP_OUT_LVL;
        end else if (ccal_r[OCG_CANCEL_BIT - 1]) begin
            probe = CMP_RAW;
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        case (AVS_ADDRESS)
            OCG_ADDR_MODE: rd_byte = {mode_r, 6'h00};
            OCG_ADDR_GAIN: rd_byte = {trip_r, 1'b0, gain_r, flen_r};
            OCG_ADDR_THR:  rd_byte = thr_r;
            OCG_ADDR_ACAL: rd_byte = acal_r;
            OCG_ADDR_CCAL: rd_byte = {probe, ccal_r};
            OCG_ADDR_MISC: rd_byte = {1'b0, src_r, 6'h00};
            default:       rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        mode_nxt  = mode_r;
        gain_nxt  = gain_r;
        flen_nxt  = flen_r;
        thr_nxt   = thr_r;
        acal_nxt  = acal_r;
        ccal_nxt  = ccal_r;
        src_nxt   = src_r;
        ack_nxt   = req & ~ack_r;
        rdata_nxt = rdata_r;
        if (AVS_READ & ~ack_r) begin
            rdata_nxt = {24'h000000, rd_byte};
        end
        if (wr_hit) begin
            case (AVS_ADDRESS)
                OCG_ADDR_MODE: mode_nxt = AVS_WRITEDATA[7:6];
                OCG_ADDR_GAIN: begin
                    gain_nxt = AVS_WRITEDATA[5:3];
                    flen_nxt = AVS_WRITEDATA[2:0];
                end
                OCG_ADDR_THR:  thr_nxt  = AVS_WRITEDATA[7:0];
                OCG_ADDR_ACAL: acal_nxt = AVS_WRITEDATA[7:0];
                OCG_ADDR_CCAL: ccal_nxt = AVS_WRITEDATA[6:0];
                OCG_ADDR_MISC: src_nxt  = AVS_WRITEDATA[OCG_MISC_SRC];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            mode_r  <= 2'h0;
            gain_r  <= 3'h0;
            flen_r  <= 3'h0;
            thr_r   <= OCG_RST_VAL;
            acal_r  <= OCG_RST_VAL;
            ccal_r  <= 7'h00;
            src_r   <= 1'b0;
            ack_r   <= 1'b0;
            rdata_r <= OCG_UNMAPPED;
        end else begin
            mode_r  <= mode_nxt;
            gain_r  <= gain_nxt;
            flen_r  <= flen_nxt;
            thr_r   <= thr_nxt;
            acal_r  <= acal_nxt;
            ccal_r  <= ccal_nxt;
            src_r   <= src_nxt;
            ack_r   <= ack_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Front-end control
    // ----------------------------------------------------------------
    // Decoded from the next register values, so the registered controls
    // change on the same edge as the registers behind them.
    logic          enabled;
    logic          en_r,  en_nxt;
    ocg_afe_ctrl_t afe_r, afe_nxt;

    assign enabled = (mode_r != OCG_MODE_OFF);
    assign en_nxt  = (mode_nxt != OCG_MODE_OFF);

    always_comb begin
        afe_nxt                    = '0;
        afe_nxt.amp_en             = en_nxt;
        afe_nxt.cmp_en             = en_nxt;
        afe_nxt.dac_en             = en_nxt;
        afe_nxt.amp_gain_sel       = gain_nxt;
        afe_nxt.threshold_code     = thr_nxt;
        afe_nxt.amp_cancel_mode    = acal_nxt[OCG_CANCEL_BIT];
        afe_nxt.amp_cancel_ref_sel = acal_nxt[OCG_REFSEL_BIT];
        afe_nxt.amp_trim_code      = acal_nxt[5:0];
        afe_nxt.cmp_cancel_mode    = ccal_nxt[6];
        afe_nxt.cmp_cancel_ref_sel = ccal_nxt[5];
        afe_nxt.cmp_trim_code      = ccal_nxt[4:0];
        afe_nxt.threshold_ref_src  = src_nxt;
        case (mode_nxt)
            OCG_MODE_OFF:  afe_nxt.sw_close = OCG_SW_OFF;
            OCG_MODE_NINV: afe_nxt.sw_close = OCG_SW_NINV;
            OCG_MODE_INV: begin
                afe_nxt.sw_close      = OCG_SW_INV;
                afe_nxt.amp_inverting = 1'b1;
            end
            OCG_MODE_ZERO: afe_nxt.sw_close = OCG_SW_ZERO;
            default:       afe_nxt.sw_close = OCG_SW_OFF;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            en_r  <= 1'b0;
            afe_r <= '{sw_close: OCG_SW_OFF, default: '0};
        end else begin
            en_r  <= en_nxt;
            afe_r <= afe_nxt;
        end
    end

    assign AFE_CTRL  = afe_r;
    assign FILTER_EN = en_r;

    // ----------------------------------------------------------------
    // Debounce filter
    // ----------------------------------------------------------------
    // A new level must be seen on 2^n ticks in a row, the first sighting
    // included; the free-running tick leaves a one-period uncertainty.
    logic [1:0]  div_r,  div_nxt;
    logic [6:0]  cnt_r,  cnt_nxt;
    logic        trip_nxt;
    ocg_fstate_t fs_r,   fs_nxt;
    logic        tick;
    logic        cmp_in;
    logic [6:0]  limit;

    assign tick   = (div_r == OCG_TICK_LAST);
    assign cmp_in = CMP_RAW & enabled;
    // Last count before the change; unused by code zero, which bypasses
    assign limit  = 7'(({7'h00, 1'b1} << flen_r) - 8'h02);

    always_comb begin
        div_nxt  = 2'(div_r + 2'h1);
        cnt_nxt  = cnt_r;
        trip_nxt = trip_r;
        fs_nxt   = fs_r;
        case (fs_r)
            OCG_FS_OFF: begin
                trip_nxt = 1'b0;
                cnt_nxt  = 7'h00;
                div_nxt  = 2'h0;
                if (enabled) begin
                    fs_nxt = OCG_FS_STABLE;
                end
            end
            OCG_FS_STABLE: begin
                cnt_nxt = 7'h00;
                if (flen_r == 3'h0) begin
                    trip_nxt = cmp_in;
                end else if (tick && cmp_in != trip_r) begin
                    fs_nxt = OCG_FS_COUNT;
                end
            end
            OCG_FS_COUNT: begin
                if (flen_r == 3'h0) begin
                    trip_nxt = cmp_in;
                    fs_nxt   = OCG_FS_STABLE;
                end else if (tick) begin
                    if (cmp_in == trip_r) begin
                        fs_nxt = OCG_FS_STABLE;
                    end else if (cnt_r >= limit) begin
                        trip_nxt = cmp_in;
                        fs_nxt   = OCG_FS_STABLE;
                    end else begin
                        cnt_nxt = 7'(cnt_r + 7'h01);
                    end
                end
            end
            default: fs_nxt = OCG_FS_OFF;
        endcase
        if (!enabled) begin
            fs_nxt   = OCG_FS_OFF;
            trip_nxt = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            div_r  <= 2'h0;
            cnt_r  <= 7'h00;
            trip_r <= 1'b0;
            fs_r   <= OCG_FS_OFF;
        end else begin
            div_r  <= div_nxt;
            cnt_r  <= cnt_nxt;
            trip_r <= trip_nxt;
            fs_r   <= fs_nxt;
        end
    end

    assign TRIP_FLAG   = trip_r;
    assign PWM_SHUTOFF = trip_r;
    assign TRIP_IRQ    = trip_r;

endmodule

// [ocg_afe_model.sv]
// Purpose : Behavioural analogue front end beside the guard register bank
// Assumes : Outputs settle within one REF_CLK cycle
// Notes   : Offsets are arbitrary trim codes at which the outputs toggle
module ocg_afe_model
    import ocg_pkg::*;
#(
    parameter int AMP_OFS = 21,
    parameter int CMP_OFS = 9
)
(
    input  wire logic          clk,
    input  wire ocg_afe_ctrl_t ctrl,
    input  wire logic [7:0]    sense_code,
    output logic               cmp_raw,
    output logic               amp_lvl
);
    timeunit 1ns;
    timeprecision 100ps;
    always @(posedge clk) begin
        amp_lvl <= ctrl.amp_en && int'(ctrl.amp_trim_code) >= AMP_OFS;
        if (!ctrl.cmp_en) begin
            cmp_raw <= 1'b0;
        end else if (ctrl.cmp_cancel_mode) begin
            cmp_raw <= int'(ctrl.cmp_trim_code) >= CMP_OFS;
        end else if (ctrl.sw_close == 4'hA) begin
            cmp_raw <= 1'b0;
        end else begin
            cmp_raw <= sense_code > ctrl.threshold_code;
        end
    end
endmodule

// [ocg_ctrl_properties.sv]
// Purpose : Port checks for the guard register bank
// Assumes : One clock domain, ARST_N disables
// Notes   : Bound to ocg_ctrl at the foot
module ocg_ctrl_props
    import ocg_pkg::*;
(
    input wire logic          REF_CLK,
    input wire logic          ARST_N,
    input wire logic          AVS_READ,
    input wire logic          AVS_WRITE,
    input wire logic [31:0]   AVS_READDATA,
    input wire logic          AVS_WAITREQUEST,
    input wire logic          CMP_RAW,
    input wire ocg_afe_ctrl_t AFE_CTRL,
    input wire logic          FILTER_EN,
    input wire logic          TRIP_FLAG,
    input wire logic          PWM_SHUTOFF,
    input wire logic          TRIP_IRQ
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    // ----
    // Checks
    // ----
    a_one_wait: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
        |=> !AVS_WAITREQUEST) else $error("wait over one cycle");
    a_wait_first: assert property ($rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST)
        else $error("no wait on first cycle");
    a_rdata_stands: assert property (!(AVS_READ && AVS_WAITREQUEST) |=> $stable(AVS_READDATA))
        else $error("read data moved");
    a_rdata_upper: assert property (AVS_READDATA[31:8] == 24'h000000)
        else $error("upper read lanes set");
    a_off_down: assert property (!FILTER_EN |-> !AFE_CTRL.amp_en && !AFE_CTRL.cmp_en
        && !AFE_CTRL.dac_en && AFE_CTRL.sw_close == 4'hA) else $error("disabled not off");
    a_on_up: assert property (FILTER_EN |-> AFE_CTRL.amp_en && AFE_CTRL.cmp_en
        && AFE_CTRL.dac_en) else $error("enabled not powered");
    a_sw_pair: assert property (FILTER_EN |-> (AFE_CTRL.amp_inverting ?
        AFE_CTRL.sw_close == 4'h6 : AFE_CTRL.sw_close inside {4'h9, 4'hA}))
        else $error("switch pair wrong");
    a_off_trip: assert property (!FILTER_EN |=> !TRIP_FLAG) else $error("trip while off");
    a_trip_fanout: assert property (TRIP_FLAG == PWM_SHUTOFF && TRIP_FLAG == TRIP_IRQ)
        else $error("trip outputs differ");
    a_trip_cause: assert property ($rose(TRIP_FLAG) |-> $past(CMP_RAW) || $past(CMP_RAW, 2))
        else $error("trip without comparator");
    c_trip: cover property ($rose(TRIP_FLAG));
    c_read: cover property (AVS_READ && !AVS_WAITREQUEST);
    c_write: cover property (AVS_WRITE && !AVS_WAITREQUEST);
endmodule
bind ocg_ctrl ocg_ctrl_props i_ocg_ctrl_props (.REF_CLK, .ARST_N, .AVS_READ, .AVS_WRITE,
    .AVS_READDATA, .AVS_WAITREQUEST, .CMP_RAW, .AFE_CTRL, .FILTER_EN, .TRIP_FLAG,
    .PWM_SHUTOFF, .TRIP_IRQ);

// [ocg_ctrl_tb_top.sv]
// Purpose : Self-checking bench for the guard register bank
// Assumes : Avalon-MM master, analogue model on the far side
// Notes   : Expectations come from the register model below
module ocg_ctrl_tb_top
    import ocg_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int AMP_OFS = 21;
    localparam int CMP_OFS = 9;
    localparam int MASK[8] = '{8'hC0, 8'h3F, 8'hFF, 8'hFF, 8'h7F, 8'h40, 8'h00, 8'h00};
    logic          REF_CLK = 1'b0;
    logic          ARST_N = 1'b0;
    logic [4:0]    AVS_ADDRESS = 5'h00;
    logic          AVS_READ = 1'b0;
    logic          AVS_WRITE = 1'b0;
    logic [31:0]   AVS_WRITEDATA = 32'h00000000;
    logic [3:0]    AVS_BYTEENABLE = 4'h0;
    logic [31:0]   AVS_READDATA, rdat;
    logic          AVS_WAITREQUEST, CMP_RAW, AMP_OUT_LVL, FILTER_EN, TRIP_FLAG;
    logic          PWM_SHUTOFF, TRIP_IRQ;
    ocg_afe_ctrl_t AFE_CTRL;
    logic [7:0]    sense = 8'h00;
    int            regs[8];
    int            n_fail = 0, samples_checked = 0, cyc = 0, seed = 22;

    always #2.5 REF_CLK = ~REF_CLK;
    ocg_ctrl i_ocg_ctrl (.REF_CLK, .ARST_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
        .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .CMP_RAW, .AMP_OUT_LVL, .AFE_CTRL,
        .FILTER_EN, .TRIP_FLAG, .PWM_SHUTOFF, .TRIP_IRQ);
    ocg_afe_model #(.AMP_OFS(AMP_OFS), .CMP_OFS(CMP_OFS)) i_ocg_afe_model (.clk(REF_CLK),
        .ctrl(AFE_CTRL), .sense_code(sense), .cmp_raw(CMP_RAW), .amp_lvl(AMP_OUT_LVL));
    // ----
    // Tasks
    // ----
    task automatic close_out;
        $display("Checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Request held until waitrequest is seen low at a rising edge
    task automatic wr(input int a, input logic [7:0] d, input logic be);
        AVS_ADDRESS <= 5'(a * 4);
        AVS_WRITEDATA <= {24'h000000, d};
        AVS_BYTEENABLE <= {3'h7, be};
        AVS_WRITE <= 1'b1;
        do @(posedge REF_CLK); while (AVS_WAITREQUEST !== 1'b0);
        AVS_WRITE <= 1'b0;
        @(posedge REF_CLK);
        if (be) regs[a] = d & MASK[a];
    endtask
    task automatic rd(input int a);
        AVS_ADDRESS <= 5'(a * 4);
        AVS_READ <= 1'b1;
        do @(posedge REF_CLK); while (AVS_WAITREQUEST !== 1'b0);
        rdat = AVS_READDATA;
        AVS_READ <= 1'b0;
        @(posedge REF_CLK);
    endtask
    task automatic check_afe;
        int m;
        m = regs[0] >> 6;
        chk("en", 32'(m != 0), 32'(FILTER_EN));
        chk("sw", m == 1 ? 32'h9 : m == 2 ? 32'h6 : 32'hA, 32'(AFE_CTRL.sw_close));
        chk("inv", 32'(m == 2), 32'(AFE_CTRL.amp_inverting));
        chk("gain", 32'(regs[1] >> 3), 32'(AFE_CTRL.amp_gain_sel));
        chk("thr", 32'(regs[2]), 32'(AFE_CTRL.threshold_code));
        chk("acal", 32'(regs[3]), 32'(AFE_CTRL[15:8]));
        chk("ccal", 32'(regs[4]), 32'(AFE_CTRL[7:1]));
        chk("src", 32'(regs[5] >> 6), 32'(AFE_CTRL.threshold_ref_src));
    endtask
    // Persistence window: whole ticks of four cycles, plus pipeline slack
    task automatic lat(input int n, input logic lvl);
        int t;
        int hi;
        t = 0;
        hi = n == 0 ? 4 : 4 * ((1 << n) - 1) + 8;
        sense <= lvl ? 8'h80 : 8'h00;
        while (TRIP_FLAG !== lvl && t <= hi) begin
            @(posedge REF_CLK);
            t++;
        end
        chk("lat_min", 32'h1, 32'(t >= 4 * ((1 << n) - 1) + 2));
        chk("lat_max", 32'h1, 32'(t <= hi));
    endtask
    always @(posedge REF_CLK) begin
        cyc++;
        if (cyc == 12000) begin
            n_fail++;
            $display("Error timeout expected done seen hang");
            close_out();
        end
    end
    // ----
    // Sequence
    // ----
    initial begin
        repeat (12) @(posedge REF_CLK);
        ARST_N <= 1'b1;
        repeat (3) @(posedge REF_CLK);
        for (int a = 0; a < 8; a++) begin
            rd(a);
            chk("reset", 32'h0, rdat);
        end
        for (int m = 0; m < 4; m++) begin
            wr(0, 8'(m << 6) | 8'h3F, 1'b1);
            check_afe();
        end
        for (int i = 0; i < 32; i++) begin
            int a;
            logic [7:0] d;
            a = {$random(seed)} % 8;
            d = 8'($random(seed)) & ~(a == 3 ? 8'h80 : a == 4 ? 8'h40 : 8'h00);
            wr(a, d, 1'($random(seed)));
            rd(a);
            chk("reg", 32'(regs[a]), rdat);
            check_afe();
        end
        $display("test registers done");
        wr(4, 8'h00, 1'b1);
        wr(0, 8'hC0, 1'b1);
        for (int k = 0; k < 96; k++) begin
            int t;
            t = k < 64 ? k : 95 - k;
            if (k == 64) wr(3, 8'h00, 1'b1);
            if (k < 64) wr(3, 8'h80 | 8'(t), 1'b1);
            else wr(4, 8'h40 | 8'(t), 1'b1);
            rd(4);
            chk("probe", 32'(t >= (k < 64 ? AMP_OFS : CMP_OFS)), 32'(rdat[7]));
        end
        wr(0, 8'h00, 1'b1);
        wr(4, 8'h00, 1'b1);
        $display("test calibration done");
        wr(2, 8'h40, 1'b1);
        wr(0, 8'h40, 1'b1);
        for (int n = 0; n < 8; n++) begin
            wr(1, 8'(n), 1'b1);
            check_afe();
            if (n == 5) begin
                sense <= 8'h80;
                repeat (64) @(posedge REF_CLK);
                sense <= 8'h00;
                repeat (200) @(posedge REF_CLK);
                chk("glitch", 32'h0, 32'(TRIP_FLAG));
            end
            lat(n, 1'b1);
            wr(1, 8'(n), 1'b1);
            rd(1);
            chk("trip_bit", 32'h80 | 32'(n), rdat);
            chk("shutoff", 32'h1, 32'(PWM_SHUTOFF));
            chk("irq", 32'h1, 32'(TRIP_IRQ));
            lat(n, 1'b0);
        end
        $display("test filter done");
        close_out();
    end
endmodule
